//--- adcs_out_ctrl.sv
// adcs_out_ctrl: decimation, clipping, settling blank and serial master
// output of a delta-sigma converter, plus reference and power-down control.
// assumes: mod_sample is produced on clk_samp; sync_in, power_down_n and
// ext_ref_select are pins; clk_samp may stop during power-down.
`timescale 1ns/1ps

// Summary of operation
// - every result leaves as a 16-bit two's complement word.
// - above positive full scale the word clips to 7FFFh and flags out of range.
// - below negative full scale the word clips to 8000h and flags out of range.
// - the out-of-range flag is a level held while the input stays outside.
// - the flag rises on a serial clock falling edge when the code overflows.
// - the flag falls on a serial clock falling edge once back in range.
// - zero gives 0000h, one step below gives FFFFh, full scale unflagged.
// - the device is master, generating frame strobe and serial clock.
// - inverted copies of frame strobe, serial clock and data are driven.
// - after common sync all devices frame words on identical cycles.
// - after sync the frame strobe stays low until the filter settles.
// - the filtered output needs 51 conversion cycles to settle.
// - power-down input low shuts everything, reference generators included.
// - external reference select high disables all three reference generators.
// - filter response and word rate scale with the sampling clock.
// - one output word for every sixteen sampling clock cycles.
// - sync counts only when high a full sampling period; host holds it so.
// - serial transfers start only after sync is released.
// - a frame strobe tells the receiver a new word is available.
module adcs_out_ctrl #(
    parameter int IN_W = adcs_pkg::IN_W_DEF,
    parameter logic [7:0] SCLK_HALF = adcs_pkg::SCLK_HALF_DEF
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic clk_samp,
    input wire logic signed [IN_W-1:0] mod_sample,
    input wire logic sync_in,
    input wire logic power_down_n,
    input wire logic ext_ref_select,
    output adcs_pkg::adcs_ser_t ser_out,
    output adcs_pkg::adcs_ser_t ser_out_n,
    output logic out_of_range_flag,
    output logic filter_settled,
    output adcs_pkg::adcs_ref_t ref_gen_en
);
    import adcs_pkg::*;

    localparam int SUM_W = IN_W + DECIM_LOG2;
    localparam logic [7:0] DIV_LAST = SCLK_HALF - 8'h01;

    // ------------------------------------------------------------
    // reset release, one copy per clock
    // ------------------------------------------------------------
    logic [1:0] rst_sys_q;
    logic [1:0] rst_samp_q;
    logic rst_sys_n;
    logic rst_samp_n;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rst_sys_q <= 2'b00;
        end else begin
            rst_sys_q <= {rst_sys_q[0], 1'b1};
        end
    end

    always_ff @(posedge clk_samp or negedge nrst) begin
        if (!nrst) begin
            rst_samp_q <= 2'b00;
        end else begin
            rst_samp_q <= {rst_samp_q[0], 1'b1};
        end
    end

    assign rst_sys_n = rst_sys_q[1];
    assign rst_samp_n = rst_samp_q[1];

    // ------------------------------------------------------------
    // pin inputs on the system clock
    // ------------------------------------------------------------
    logic [2:0] pd_pin_q;
    logic [2:0] ref_pin_q;
    logic pd_up;
    logic ext_ref;

    always_ff @(posedge clk_sys or negedge rst_sys_n) begin
        if (!rst_sys_n) begin
            pd_pin_q <= PIN_HIGH_RST;
            ref_pin_q <= PIN_LOW_RST;
            pd_up <= 1'b1;
            ext_ref <= 1'b0;
        end else begin
            pd_pin_q <= {pd_pin_q[1:0], power_down_n};
            ref_pin_q <= {ref_pin_q[1:0], ext_ref_select};
            if (pd_pin_q[1] == pd_pin_q[2]) begin
                pd_up <= pd_pin_q[2];
            end
            if (ref_pin_q[1] == ref_pin_q[2]) begin
                ext_ref <= ref_pin_q[2];
            end
        end
    end

    // reference generators off in power-down or with external reference
    always_ff @(posedge clk_sys or negedge rst_sys_n) begin
        if (!rst_sys_n) begin
            ref_gen_en <= REF_OFF;
        end else if (!pd_up || ext_ref) begin
            ref_gen_en <= REF_OFF;
        end else begin
            ref_gen_en <= '{pos: 1'b1, neg: 1'b1, mid: 1'b1};
        end
    end

    // ------------------------------------------------------------
    // sampling-clock side: sync, power state, decimation
    // ------------------------------------------------------------
    logic [2:0] sync_q;
    logic sync_lvl;
    logic [1:0] pd_samp_q;
    logic inited;
    logic run;

    always_ff @(posedge clk_samp or negedge rst_samp_n) begin
        if (!rst_samp_n) begin
            sync_q <= PIN_LOW_RST;
            sync_lvl <= 1'b0;
            pd_samp_q <= 2'b11;
            inited <= 1'b0;
        end else begin
            sync_q <= {sync_q[1:0], sync_in};
            pd_samp_q <= {pd_samp_q[0], pd_up};
            if (sync_q[1] == sync_q[2]) begin
                sync_lvl <= sync_q[2];
            end
            if (sync_lvl) begin
                inited <= 1'b1;
            end
        end
    end

    // conversions only after sync release and while powered
    assign run = inited && !sync_lvl && pd_samp_q[1];

    logic [3:0] phase;
    logic signed [SUM_W-1:0] acc;
    logic signed [SUM_W-1:0] next_sum;
    logic signed [IN_W-1:0] avg;
    logic in_range;
    logic [WORD_W-1:0] next_code;

    always_comb begin
        next_sum = acc + {{DECIM_LOG2{mod_sample[IN_W-1]}}, mod_sample};
        avg = next_sum[SUM_W-1:DECIM_LOG2];
        in_range = (&avg[IN_W-1:WORD_W-1]) || !(|avg[IN_W-1:WORD_W-1]);
        if (in_range) begin
            next_code = avg[WORD_W-1:0];
        end else if (avg[IN_W-1]) begin
            next_code = CODE_NEG_FS;
        end else begin
            next_code = CODE_POS_FS;
        end
    end

    // phase counter on the sampling clock sets the word rate
    always_ff @(posedge clk_samp or negedge rst_samp_n) begin
        if (!rst_samp_n) begin
            phase <= 4'h0;
            acc <= '0;
        end else if (!run) begin
            phase <= 4'h0;
            acc <= '0;
        end else begin
            phase <= phase + 4'h1;
            if (phase == PHASE_LAST) begin
                acc <= '0;
            end else begin
                acc <= next_sum;
            end
        end
    end

    logic [5:0] settle_cnt;
    logic settled;
    logic [WORD_W-1:0] word_data;
    logic word_otr;
    logic word_tgl;

    assign settled = (settle_cnt == SETTLE_WORDS);

    always_ff @(posedge clk_samp or negedge rst_samp_n) begin
        if (!rst_samp_n) begin
            settle_cnt <= 6'h00;
            word_data <= '0;
            word_otr <= 1'b0;
            word_tgl <= 1'b0;
        end else if (!run) begin
            settle_cnt <= 6'h00;
        end else if (phase == PHASE_LAST) begin
            if (!settled) begin
                settle_cnt <= settle_cnt + 6'h01;
            end else begin
                word_data <= next_code;
                word_otr <= !in_range;
                word_tgl <= !word_tgl;
            end
        end
    end

    // ------------------------------------------------------------
    // crossing to the system clock
    // ------------------------------------------------------------
    logic [2:0] tgl_q;
    logic [1:0] settled_q;
    logic new_word;

    always_ff @(posedge clk_sys or negedge rst_sys_n) begin
        if (!rst_sys_n) begin
            tgl_q <= 3'h0;
            settled_q <= 2'b00;
        end else begin
            tgl_q <= {tgl_q[1:0], word_tgl};
            settled_q <= {settled_q[0], settled};
        end
    end

    assign new_word = tgl_q[1] ^ tgl_q[2];
    assign filter_settled = settled_q[1];

    // word registers are stable for many system cycles after a toggle
    logic pending;
    logic [WORD_W-1:0] hold_data;
    logic hold_otr;
    logic take;

    always_ff @(posedge clk_sys or negedge rst_sys_n) begin
        if (!rst_sys_n) begin
            hold_data <= '0;
            hold_otr <= 1'b0;
        end else if (new_word) begin
            hold_data <= word_data;
            hold_otr <= word_otr;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sys_n) begin
        if (!rst_sys_n) begin
            pending <= 1'b0;
        end else if (!pd_up) begin
            pending <= 1'b0;
        end else begin
            pending <= new_word || (pending && !take);
        end
    end

    // ------------------------------------------------------------
    // serial clock generation
    // ------------------------------------------------------------
    logic [7:0] div_cnt;
    logic tick;
    logic rise;
    logic fall;

    assign tick = (div_cnt == DIV_LAST);
    assign rise = tick && !ser_out.sclk;
    assign fall = tick && ser_out.sclk;

    always_ff @(posedge clk_sys or negedge rst_sys_n) begin
        if (!rst_sys_n) begin
            div_cnt <= 8'h00;
        end else if (!pd_up || tick) begin
            div_cnt <= 8'h00;
        end else begin
            div_cnt <= div_cnt + 8'h01;
        end
    end

    // ------------------------------------------------------------
    // serializer
    // ------------------------------------------------------------
    adcs_state_t state;
    adcs_state_t next_state;
    adcs_ser_t next_ser;
    logic [WORD_W-1:0] shreg;
    logic [WORD_W-1:0] next_shreg;
    logic [3:0] bit_cnt;
    logic [3:0] next_bit_cnt;
    logic frame_otr;

    always_comb begin
        next_state = state;
        next_ser = ser_out;
        next_shreg = shreg;
        next_bit_cnt = bit_cnt;
        take = 1'b0;
        if (!pd_up) begin
            next_state = ST_IDLE;
            next_ser = SER_RST;
        end else if (tick) begin
            next_ser.sclk = !ser_out.sclk;
            if (rise) begin
                case (state)
                    ST_IDLE: begin
                        if (pending) begin
                            take = 1'b1;
                            next_ser.frame_sync_out = 1'b1;
                            next_ser.dout = hold_data[WORD_W-1];
                            next_shreg = {hold_data[WORD_W-2:0], 1'b0};
                            next_bit_cnt = BIT_LAST;
                            next_state = ST_SHIFT;
                        end
                    end
                    ST_SHIFT: begin
                        next_ser.frame_sync_out = 1'b0;
                        if (bit_cnt == 4'h1) begin
                            next_ser.dout = shreg[WORD_W-1];
                            next_bit_cnt = 4'h0;
                        end else if (bit_cnt == 4'h0) begin
                            next_ser.dout = 1'b0;
                            next_state = ST_IDLE;
                        end else begin
                            next_ser.dout = shreg[WORD_W-1];
                            next_shreg = {shreg[WORD_W-2:0], 1'b0};
                            next_bit_cnt = bit_cnt - 4'h1;
                        end
                    end
                    default: begin
                        next_state = ST_IDLE;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sys_n) begin
        if (!rst_sys_n) begin
            state <= ST_IDLE;
            shreg <= '0;
            bit_cnt <= 4'h0;
            frame_otr <= 1'b0;
        end else begin
            state <= next_state;
            shreg <= next_shreg;
            bit_cnt <= next_bit_cnt;
            if (take) begin
                frame_otr <= hold_otr;
            end
        end
    end

    // true and inverted copies leave from flops together
    always_ff @(posedge clk_sys or negedge rst_sys_n) begin
        if (!rst_sys_n) begin
            ser_out <= SER_RST;
            ser_out_n <= adcs_ser_t'(~SER_RST);
        end else begin
            ser_out <= next_ser;
            ser_out_n <= adcs_ser_t'(~next_ser);
        end
    end

    // flag follows the framed word at the falling edge of its first bit
    always_ff @(posedge clk_sys or negedge rst_sys_n) begin
        if (!rst_sys_n) begin
            out_of_range_flag <= 1'b0;
        end else if (!pd_up) begin
            out_of_range_flag <= 1'b0;
        end else if (fall && ser_out.frame_sync_out) begin
            out_of_range_flag <= frame_otr;
        end
    end

endmodule

//--- adcs_pkg.sv
// adcs_pkg: constants and carrier types of the converter output block.
// assumes: the sampling-clock side and the system-clock side both import it.
package adcs_pkg;

    // ------------------------------------------------------------
    // conversion and framing
    // ------------------------------------------------------------
    localparam int DECIM_LOG2 = 4;
    localparam logic [3:0] PHASE_LAST = 4'hF;
    localparam int WORD_W = 16;
    localparam logic [15:0] CODE_POS_FS = 16'h7FFF;
    localparam logic [15:0] CODE_NEG_FS = 16'h8000;
    localparam logic [5:0] SETTLE_WORDS = 6'h33;
    localparam logic [3:0] BIT_LAST = 4'hF;
    localparam int IN_W_DEF = 18;

    // ------------------------------------------------------------
    // serial clock divider and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] SCLK_HALF_DEF = 8'h04;
    localparam logic [2:0] PIN_HIGH_RST = 3'h7;
    localparam logic [2:0] PIN_LOW_RST = 3'h0;

    typedef struct packed {
        logic frame_sync_out;
        logic sclk;
        logic dout;
    } adcs_ser_t;

    typedef struct packed {
        logic pos;
        logic neg;
        logic mid;
    } adcs_ref_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_SHIFT = 2'b10
    } adcs_state_t;

    localparam adcs_ser_t SER_RST = '{frame_sync_out: 1'b0, sclk: 1'b0, dout: 1'b0};
    localparam adcs_ref_t REF_OFF = '{pos: 1'b0, neg: 1'b0, mid: 1'b0};

endpackage

//--- adcs_out_ctrl_assertions.sv
// adcs_out_ctrl_assertions: port checks on the converter output block.
// assumes: bound to adcs_out_ctrl; clk_sys domain, nrst active low.
`timescale 1ns/1ps
module adcs_out_ctrl_assertions #(
    parameter int IN_W = adcs_pkg::IN_W_DEF,
    parameter logic [7:0] SCLK_HALF = adcs_pkg::SCLK_HALF_DEF
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic clk_samp,
    input wire logic signed [IN_W-1:0] mod_sample,
    input wire logic sync_in,
    input wire logic power_down_n,
    input wire logic ext_ref_select,
    input wire adcs_pkg::adcs_ser_t ser_out,
    input wire adcs_pkg::adcs_ser_t ser_out_n,
    input wire logic out_of_range_flag,
    input wire logic filter_settled,
    input wire adcs_pkg::adcs_ref_t ref_gen_en
);
    import adcs_pkg::*;
    logic [7:0] fso_len;
    logic [3:0] pd_hi;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // --------------------------------------------
    // helper counters
    // --------------------------------------------
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            fso_len <= 8'h00;
        end else if (ser_out.frame_sync_out) begin
            fso_len <= fso_len + 8'h01;
        end else begin
            fso_len <= 8'h00;
        end
    end
    // pin high long enough for the block to be running
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            pd_hi <= 4'h0;
        end else if (!power_down_n) begin
            pd_hi <= 4'h0;
        end else if (pd_hi != 4'hF) begin
            pd_hi <= pd_hi + 4'h1;
        end
    end
    // --------------------------------------------
    // properties
    // --------------------------------------------
    property p_inv; {ser_out_n} == ~{ser_out}; endproperty
    a_inv: assert property (p_inv) else $error("inverted outputs wrong");
    property p_fso_len;
        $fell(ser_out.frame_sync_out) && pd_hi == 4'hF |-> fso_len == {SCLK_HALF[6:0], 1'b0};
    endproperty
    a_fso_len: assert property (p_fso_len) else $error("strobe length wrong");
    property p_fso_sclk; $rose(ser_out.frame_sync_out) |-> $rose(ser_out.sclk); endproperty
    a_fso_sclk: assert property (p_fso_sclk) else $error("strobe off clock rise");
    property p_settled; ser_out.frame_sync_out |-> filter_settled; endproperty
    a_settled: assert property (p_settled) else $error("frame before settling");
    property p_dout;
        $changed(ser_out.dout) && pd_hi == 4'hF |-> $rose(ser_out.sclk);
    endproperty
    a_dout: assert property (p_dout) else $error("data moved off clock rise");
    property p_flag;
        $changed(out_of_range_flag) && pd_hi == 4'hF |-> $fell(ser_out.sclk) && ser_out.frame_sync_out;
    endproperty
    a_flag: assert property (p_flag) else $error("flag moved off clock fall");
    property p_pd;
        !power_down_n [*8] |-> {ser_out, out_of_range_flag, ref_gen_en} == 7'h00;
    endproperty
    a_pd: assert property (p_pd) else $error("active in power-down");
    property p_ext; ext_ref_select [*8] |-> ref_gen_en == 3'h0; endproperty
    a_ext: assert property (p_ext) else $error("generators on with ext ref");
    property p_ref_on;
        (power_down_n && !ext_ref_select) [*8] |-> ##2 ref_gen_en == 3'h7;
    endproperty
    a_ref_on: assert property (p_ref_on) else $error("generators off");
endmodule

bind adcs_out_ctrl adcs_out_ctrl_assertions #(.IN_W(IN_W), .SCLK_HALF(SCLK_HALF)) u_chk (
    .clk_sys(clk_sys), .nrst(nrst), .clk_samp(clk_samp), .mod_sample(mod_sample),
    .sync_in(sync_in), .power_down_n(power_down_n), .ext_ref_select(ext_ref_select),
    .ser_out(ser_out), .ser_out_n(ser_out_n), .out_of_range_flag(out_of_range_flag),
    .filter_settled(filter_settled), .ref_gen_en(ref_gen_en));

//--- adcs_rx_model.sv
// adcs_rx_model: serial receive port on the far side of the converter.
// assumes: it samples strobe, clock, data and the out-of-range flag driven by the block.
`timescale 1ns/1ps
module adcs_rx_model (
    input wire adcs_pkg::adcs_ser_t ser,
    input wire logic flag,
    output logic [15:0] word,
    output logic word_flag,
    output int count
);
    import adcs_pkg::*;
    logic [15:0] shift;
    int nbits;
    initial begin
        word = 16'h0000;
        word_flag = 1'b0;
        count = 0;
        nbits = 0;
        forever begin
            @(negedge ser.sclk);
            if (ser.frame_sync_out) begin
                shift = {15'h0, ser.dout};
                nbits = 1;
            end else if (nbits > 0) begin
                shift = {shift[14:0], ser.dout};
                nbits++;
            end
            if (nbits == 16) begin
                word = shift;
                word_flag = flag;
                count++;
                nbits = 0;
            end
        end
    end
endmodule

//--- testbench.sv
// testbench: self-checking bench of the converter output block.
// assumes: design defaults IN_W 18, SCLK_HALF 4.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin \
    $display("unexpected %s: expected %h seen %h", nm, e, g); err_count++; end end
module testbench;
    import adcs_pkg::*;
    logic clk_sys = 1'b0;
    logic clk_samp = 1'b0;
    logic samp_run = 1'b1;
    logic nrst = 1'b0;
    logic signed [17:0] mod_sample = 18'h00000;
    logic sync_in = 1'b0;
    logic power_down_n = 1'b1;
    logic ext_ref_select = 1'b0;
    adcs_ser_t ser_out;
    adcs_ser_t ser_out_n;
    logic out_of_range_flag;
    logic filter_settled;
    adcs_ref_t ref_gen_en;
    logic [15:0] rx_word;
    logic rx_flag;
    int rx_count;
    int err_count = 0;
    int compares = 0;
    logic signed [17:0] corner [8] = '{18'h00000, 18'h3FFFF, 18'h07FFF, 18'h38000,
        18'h08000, 18'h37FFF, 18'h1FFFF, 18'h20000};
    initial forever #2.5 clk_sys = ~clk_sys;
    // sampling clock stops low while samp_run is clear
    initial begin
        #37;
        forever #80 clk_samp = samp_run ? ~clk_samp : 1'b0;
    end
    adcs_out_ctrl DUT (.clk_sys(clk_sys), .nrst(nrst), .clk_samp(clk_samp),
        .mod_sample(mod_sample), .sync_in(sync_in), .power_down_n(power_down_n),
        .ext_ref_select(ext_ref_select), .ser_out(ser_out), .ser_out_n(ser_out_n),
        .out_of_range_flag(out_of_range_flag), .filter_settled(filter_settled),
        .ref_gen_en(ref_gen_en));
    adcs_rx_model u_rx (.ser(ser_out), .flag(out_of_range_flag), .word(rx_word),
        .word_flag(rx_flag), .count(rx_count));
    // --------------------------------------------
    // tasks
    // --------------------------------------------
    task automatic complete_run;
        if (err_count == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    function automatic logic [16:0] expect_out(input logic signed [17:0] v);
        if (v > 18'sd32767) return {1'b1, CODE_POS_FS};
        if (v < -18'sd32768) return {1'b1, CODE_NEG_FS};
        return {1'b0, v[15:0]};
    endfunction
    task automatic wait_frames(input int n);
        int t;
        t = rx_count + n;
        for (int i = 0; i < 6000 && rx_count < t; i++) @(negedge clk_sys);
        `CHK("frame arrival", 1'b1, rx_count >= t)
        if (rx_count < t) complete_run();
    endtask
    task automatic wait_settled(output int n);
        for (n = 0; n < 900 && filter_settled !== 1'b1; n++) @(posedge clk_samp);
    endtask
    // constant input for three words, so the last framed word is whole
    task automatic check_value(input logic signed [17:0] v);
        logic [16:0] e;
        e = expect_out(v);
        @(negedge clk_samp);
        mod_sample = v;
        wait_frames(3);
        `CHK("word", e[15:0], rx_word)
        `CHK("framed flag", e[16], rx_flag)
        `CHK("flag level", e[16], out_of_range_flag)
    endtask
    // --------------------------------------------
    // main sequence
    // --------------------------------------------
    initial begin
        int n;
        void'($urandom(22));
        repeat (16) @(posedge clk_samp);
        @(negedge clk_sys);
        `CHK("reset outputs", 10'h070, {ser_out, ser_out_n, out_of_range_flag, ref_gen_en})
        `CHK("reset settled", 1'b0, filter_settled)
        nrst = 1'b1;
        repeat (12) @(negedge clk_sys);
        `CHK("ref enables", 3'h7, ref_gen_en)
        ext_ref_select = 1'b1;
        repeat (12) @(negedge clk_sys);
        `CHK("ref enables ext", 3'h0, ref_gen_en)
        ext_ref_select = 1'b0;
        @(negedge clk_samp);
        sync_in = 1'b1;
        repeat (3) @(negedge clk_samp);
        sync_in = 1'b0;
        wait_settled(n);
        `CHK("settle edges", 1'b1, n >= 816 && n <= 840)
        `CHK("frames before settle", 0, rx_count)
        foreach (corner[i]) check_value(corner[i]);
        repeat (6) check_value(18'($urandom));
        @(negedge clk_sys);
        power_down_n = 1'b0;
        // let the sampling side see power-down before its clock stops
        repeat (80) @(negedge clk_sys);
        samp_run = 1'b0;
        repeat (40) @(negedge clk_sys);
        `CHK("power-down outputs", 7'h00, {ser_out, out_of_range_flag, ref_gen_en})
        samp_run = 1'b1;
        power_down_n = 1'b1;
        repeat (200) @(negedge clk_sys);
        `CHK("unsettled after wake", 1'b0, filter_settled)
        wait_settled(n);
        `CHK("settled after wake", 1'b1, filter_settled)
        check_value(18'h01234);
        complete_run();
    end
endmodule
